// ==== verilog/rsh_consts.svh ====
// constants for the reader serial host port controller
`ifndef RSH_CONSTS_SVH
`define RSH_CONSTS_SVH
`define RSH_MODE_WRITE     2'h0
`define RSH_MODE_READ      2'h1
`define RSH_MODE_FIFO      2'h2
`define RSH_MODE_CMD       2'h3
`define RSH_TRAIL_LOAD     6'h00
`define RSH_TRAIL_FIFO_RD  6'h3F
`define RSH_FIFO_MAX       7'h60
`define RSH_CLK_NS         40
`define RSH_SCLK_MIN_NS    167
`define RSH_SSH_MIN_NS     100
`define RSH_NCSL_MIN_NS    25
`define RSH_NCSH_MIN_NS    300
`define RSH_CEIL(t)        (((t) + `RSH_CLK_NS - 1) / `RSH_CLK_NS)
`endif

// ==== verilog/rsh_pkg.sv ====
// types for the reader serial host port controller
package rsh_pkg;
  typedef enum logic [1:0] {
    RSH_OP_WRITE,
    RSH_OP_READ,
    RSH_OP_FIFO_LOAD,
    RSH_OP_FIFO_READ
  } rsh_op_t;

  typedef struct packed {
    rsh_op_t    op;
    logic [5:0] addr;
    logic [6:0] count;
    logic [5:0] cmd;
    logic       has_cmd;
    logic       long_cmd;
  } rsh_req_t;

  typedef struct packed {
    logic sclk;
    logic ss_n;
    logic mosi;
    logic mosi_oe;
  } rsh_pins_t;
endpackage

// ==== verilog/rsh_buf.sv ====
// small byte memory holding staged write data
`timescale 1ns/1ps
module rsh_buf #(
  parameter int DEPTH = 96,
  parameter int AW    = 7
) (
  input  wire logic          clk_i,
  input  wire logic          ce_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  logic [7:0] mem [DEPTH];

  always_ff @(posedge clk_i) begin
    if (ce_i && we_i) begin
      mem[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      rdata_o <= mem[raddr_i];
    end
  end
endmodule // rsh_buf

// ==== verilog/rsh_host.sv ====
// serial port master driving the reader device pins
`timescale 1ns/1ps
`include "rsh_consts.svh"
module rsh_host #(
  parameter int DEPTH    = 96,
  parameter int HALF_CYC = (`RSH_SCLK_MIN_NS + 2 * `RSH_CLK_NS - 1) / (2 * `RSH_CLK_NS),
  parameter int IRQ_WAIT = 100000
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              ce_i,
  input  wire rsh_pkg::rsh_req_t req_i,
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              wr_valid_i,
  input  wire logic [7:0]        wr_data_i,
  output logic                   wr_ready_o,
  output logic                   rd_valid_o,
  output logic      [7:0]        rd_data_o,
  output logic                   busy_o,
  output logic                   timeout_o,
  input  wire logic              miso_i,
  input  wire logic              irq_i,
  input  wire logic              fifo_ok_i,
  output rsh_pkg::rsh_pins_t     pins_o
);
  import rsh_pkg::*;

  localparam int SSH_CYC  = `RSH_CEIL(`RSH_SSH_MIN_NS);
  localparam int NCSL_CYC = `RSH_CEIL(`RSH_NCSL_MIN_NS);
  localparam int NCSH_CYC = `RSH_CEIL(`RSH_NCSH_MIN_NS);

  typedef enum logic [2:0] {
    ST_IDLE, ST_LEAD, ST_BYTE, ST_NEXT, ST_TAIL, ST_GAP, ST_IRQ
  } rsh_st_t;

  rsh_st_t    st_r;
  rsh_req_t   req_r;
  logic [7:0] sh_r;
  logic [2:0] bit_r;
  logic [6:0] idx_r;
  logic       hdr_r;
  logic       cmd_r;
  logic [16:0] tm_r;
  logic       sclk_r;
  logic       ss_n_r;
  logic       oe_r;
  logic [7:0] rx_r;
  logic [2:0] miso_sync_r;
  logic       miso_r;
  logic       miso_now;
  logic [2:0] irq_sync_r;
  logic       irq_r;
  logic       mosi_r;
  logic [6:0] buf_wa;
  logic [7:0] buf_rd;
  logic       read_op;
  logic [7:0] tx_byte;

  // first header byte: mode bits then six trailer bits, msb first
  function automatic logic [7:0] hdr_byte(input rsh_req_t r);
    case (r.op)
      RSH_OP_WRITE:     hdr_byte = {`RSH_MODE_WRITE, r.addr};
      RSH_OP_READ:      hdr_byte = {`RSH_MODE_READ, r.addr};
      RSH_OP_FIFO_LOAD: hdr_byte = {`RSH_MODE_FIFO, `RSH_TRAIL_LOAD};
      default:          hdr_byte = {`RSH_MODE_FIFO, `RSH_TRAIL_FIFO_RD};
    endcase
  endfunction

  function automatic logic [6:0] clip_cnt(input logic [6:0] c);
    if (c == 7'h00) clip_cnt = 7'h01;
    else if (c > `RSH_FIFO_MAX) clip_cnt = `RSH_FIFO_MAX;
    else clip_cnt = c;
  endfunction

  assign read_op = (req_r.op == RSH_OP_READ) || (req_r.op == RSH_OP_FIFO_READ);

  // outgoing bit: header/command from shifter, write data from memory
  assign tx_byte = (hdr_r || cmd_r) ? sh_r : (buf_rd << (3'h7 - bit_r));

  // level the miso stages settle on at this edge; the registered copy would be a bit late
  assign miso_now = (miso_sync_r[1] == miso_sync_r[2]) ? miso_sync_r[2] : miso_r;

  // pins are asynchronous to us: three stages, change taken when last two agree
  // limitation: read capture needs HALF_CYC of 3 or more so the stages settle before the fall
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      miso_sync_r <= 3'h0;
      miso_r      <= 1'b0;
      irq_sync_r  <= 3'h0;
      irq_r       <= 1'b0;
    end else if (ce_i) begin
      miso_sync_r <= {miso_sync_r[1:0], miso_i};
      miso_r      <= miso_now;
      irq_sync_r  <= {irq_sync_r[1:0], irq_i};
      if (irq_sync_r[1] == irq_sync_r[2]) begin
        irq_r <= irq_sync_r[2];
      end
    end
  end

  // write bytes are staged before select falls so the byte stream never stalls
  assign wr_ready_o  = (st_r == ST_IDLE) && !req_valid_i && (idx_r < DEPTH[6:0]);
  assign req_ready_o = (st_r == ST_IDLE);
  assign buf_wa      = idx_r;

  rsh_buf #(.DEPTH(DEPTH), .AW(7)) u_buf (
    .clk_i   (clk_i),
    .ce_i    (ce_i),
    .we_i    (wr_valid_i && wr_ready_o),
    .waddr_i (buf_wa),
    .wdata_i (wr_data_i),
    .raddr_i (idx_r),
    .rdata_o (buf_rd)
  );

  // main sequencer; select high between sessions resets the device port
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r      <= ST_IDLE;
      req_r     <= '0;
      sh_r      <= 8'h00;
      bit_r     <= 3'h0;
      idx_r     <= 7'h00;
      hdr_r     <= 1'b0;
      cmd_r     <= 1'b0;
      tm_r      <= 17'h0;
      sclk_r    <= 1'b0;
      ss_n_r    <= 1'b1;
      oe_r      <= 1'b0;
      mosi_r    <= 1'b0;
      rx_r      <= 8'h00;
      rd_valid_o <= 1'b0;
      rd_data_o <= 8'h00;
      timeout_o <= 1'b0;
    end else if (ce_i) begin
      rd_valid_o <= 1'b0;
      if (wr_valid_i && wr_ready_o) begin
        idx_r <= idx_r + 7'h01;
      end
      case (st_r)
        ST_IDLE: begin
          ss_n_r <= 1'b1;
          sclk_r <= 1'b0;
          oe_r   <= 1'b0;
          if (req_valid_i) begin
            req_r <= req_i;
            req_r.count <= clip_cnt(req_i.count);
            timeout_o <= 1'b0;
            // fifo modes need the device enabled and oscillator stable
            if ((req_i.op == RSH_OP_FIFO_LOAD || req_i.op == RSH_OP_FIFO_READ) && !fifo_ok_i
                && !req_i.has_cmd) begin
              idx_r <= 7'h00;
            end else begin
              st_r   <= ST_LEAD;
              ss_n_r <= 1'b0;
              tm_r   <= 17'(NCSL_CYC);
              cmd_r  <= req_i.has_cmd;
              hdr_r  <= 1'b1;
              sh_r   <= req_i.has_cmd ? {`RSH_MODE_CMD, req_i.cmd} : hdr_byte(req_i);
              idx_r  <= 7'h00;
              oe_r   <= 1'b1;
            end
          end
        end
        ST_LEAD: begin
          if (tm_r == 17'h0) begin
            st_r  <= ST_BYTE;
            bit_r <= 3'h7;
            tm_r  <= 17'(HALF_CYC);
          end else begin
            tm_r <= tm_r - 17'h1;
          end
        end
        ST_BYTE: begin
          if (tm_r != 17'h0) begin
            tm_r <= tm_r - 17'h1;
          end else if (!sclk_r) begin
            sclk_r <= 1'b1; // device launches read bit here
            // our bit changes on the rise too, so it stands still across the sampling fall
            mosi_r <= tx_byte[7];
            tm_r   <= 17'(HALF_CYC);
          end else begin
            // falling edge: device samples our bit, we capture its bit
            sclk_r <= 1'b0;
            rx_r   <= {rx_r[6:0], miso_now};
            sh_r   <= {sh_r[6:0], 1'b0};
            tm_r   <= 17'(HALF_CYC);
            if (bit_r == 3'h0) begin
              st_r <= ST_NEXT;
            end else begin
              bit_r <= bit_r - 3'h1;
            end
          end
        end
        ST_NEXT: begin
          bit_r <= 3'h7;
          if (!hdr_r && read_op) begin
            rd_valid_o <= 1'b1;
            rd_data_o  <= rx_r;
          end
          if (cmd_r) begin
            cmd_r <= 1'b0;
            if (req_r.long_cmd) begin
              st_r <= ST_TAIL;
              tm_r <= 17'(NCSH_CYC);
            end else begin
              // immediate command chains straight into the mode byte, unless a fifo mode is refused for lack of fifo_ok_i
              if ((req_r.op == RSH_OP_FIFO_LOAD || req_r.op == RSH_OP_FIFO_READ) && !fifo_ok_i) begin
                st_r <= ST_TAIL;
                tm_r <= 17'(NCSH_CYC);
              end else begin
                sh_r <= hdr_byte(req_r);
                st_r <= ST_BYTE;
                tm_r <= 17'(HALF_CYC);
              end
            end
          end else if (hdr_r || idx_r + 7'h01 < req_r.count) begin
            // in register modes the device advances its address for each further byte; fifo modes push or pop instead
            if (!hdr_r) begin
              idx_r <= idx_r + 7'h01;
            end
            hdr_r <= 1'b0;
            oe_r  <= !read_op;
            st_r  <= ST_BYTE;
            tm_r  <= 17'(HALF_CYC);
          end else begin
            st_r <= ST_TAIL;
            tm_r <= 17'(NCSH_CYC);
          end
        end
        ST_TAIL: begin
          // whole bytes only, so no write or fifo byte is cut short
          if (tm_r == 17'h0) begin
            ss_n_r <= 1'b1;
            oe_r   <= 1'b0;
            idx_r  <= 7'h00;
            if (req_r.has_cmd && req_r.long_cmd) begin
              st_r <= ST_IRQ;
              tm_r <= 17'(IRQ_WAIT);
            end else begin
              st_r <= ST_GAP;
              tm_r <= 17'(SSH_CYC);
            end
          end else begin
            tm_r <= tm_r - 17'h1;
          end
        end
        ST_IRQ: begin
          // no serial activity until the device flags completion or IRQ_WAIT cycles pass
          if (irq_r) begin
            st_r <= ST_GAP;
            tm_r <= 17'(SSH_CYC);
          end else if (tm_r == 17'h0) begin
            timeout_o <= 1'b1;
            st_r      <= ST_GAP;
            tm_r      <= 17'(SSH_CYC);
          end else begin
            tm_r <= tm_r - 17'h1;
          end
        end
        ST_GAP: begin
          if (tm_r == 17'h0) begin
            st_r <= ST_IDLE;
          end else begin
            tm_r <= tm_r - 17'h1;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign busy_o         = (st_r != ST_IDLE);
  assign pins_o.sclk    = sclk_r;
  assign pins_o.ss_n    = ss_n_r;
  assign pins_o.mosi    = oe_r ? mosi_r : 1'b0;
  assign pins_o.mosi_oe = oe_r;
endmodule // rsh_host

// ==== sim/rsh_host_properties.sv ====
// pin-level assertions for the serial host port controller
`timescale 1ns/1ps
module rsh_host_properties (
  input wire logic               clk_i,
  input wire logic               rst_i,
  input wire logic               ce_i,
  input wire rsh_pkg::rsh_req_t  req_i,
  input wire logic               req_valid_i,
  input wire logic               req_ready_o,
  input wire logic               rd_valid_o,
  input wire logic               fifo_ok_i,
  input wire rsh_pkg::rsh_pins_t pins_o
);
  import rsh_pkg::*;
  logic       sclk_q;
  logic       ssn_q;
  logic [9:0] falls_r;
  logic [3:0] since_r;
  wire        fall_now  = sclk_q & ~pins_o.sclk;
  wire  [9:0] falls_eff = falls_r + {9'h000, fall_now};
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // falls counted per session so byte framing can be judged at deselect
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      sclk_q  <= 1'b0;
      ssn_q   <= 1'b1;
      falls_r <= 10'h000;
      since_r <= 4'hF;
    end else begin
      sclk_q <= pins_o.sclk;
      ssn_q  <= pins_o.ss_n;
      if (ssn_q && !pins_o.ss_n) falls_r <= 10'h000;
      else if (fall_now) falls_r <= falls_eff;
      if (fall_now) since_r <= 4'h0;
      else if (since_r != 4'hF) since_r <= since_r + 4'h1;
    end
  end
  chk_idle_deselect: assert property (req_ready_o |-> pins_o.ss_n)
    else $error("select low while idle");
  chk_frame_start: assert property (ce_i && req_valid_i && req_ready_o && req_i.op inside {RSH_OP_WRITE, RSH_OP_READ}
    |=> !pins_o.ss_n) else $error("no select after request");
  chk_fifo_refused: assert property (ce_i && req_valid_i && req_ready_o && !fifo_ok_i && !req_i.has_cmd
    && req_i.op inside {RSH_OP_FIFO_LOAD, RSH_OP_FIFO_READ} |=> pins_o.ss_n [*4]) else $error("fifo op not refused");
  chk_sel_setup: assert property ($fell(pins_o.ss_n) |-> !pins_o.sclk)
    else $error("clock high at select");
  chk_sclk_idle: assert property (pins_o.ss_n |-> !pins_o.sclk)
    else $error("clock moves while deselected");
  chk_mosi_hold: assert property ($fell(pins_o.sclk) && pins_o.mosi_oe |-> $stable(pins_o.mosi))
    else $error("data changed at sampling edge");
  chk_whole_bytes: assert property ($rose(pins_o.ss_n) |-> falls_r[2:0] == 3'h0 && falls_r != 10'h000)
    else $error("session not whole bytes");
  chk_select_hold: assert property ($rose(pins_o.ss_n) |-> since_r >= 4'h7)
    else $error("deselect too soon after last clock");
  chk_read_align: assert property (rd_valid_o |-> falls_eff[2:0] == 3'h0 && falls_eff >= 10'h010)
    else $error("read byte off byte boundary");
endmodule // rsh_host_properties

bind rsh_host rsh_host_properties u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .req_i(req_i),
  .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .fifo_ok_i(fifo_ok_i),
  .pins_o(pins_o));

// ==== sim/rsh_dev_model.sv ====
// behavioural reader device answering on the serial port
`timescale 1ns/1ps
module rsh_dev_model #(
  parameter logic [5:0] RO_ADDR  = 6'h1F,
  parameter logic [7:0] RO_VAL   = 8'hA5,
  parameter logic [5:0] PD_ADDR  = 6'h02,
  parameter logic [5:0] LONG_CMD = 6'h3E,
  parameter int         LONG_NS  = 600
) (
  input  wire logic sclk_i,
  input  wire logic ss_n_i,
  input  wire logic mosi_i,
  input  wire logic en_i,
  input  wire logic irq_mute_i,
  output logic      miso_o,
  output logic      irq_o
);
  logic [7:0] regs[0:31];
  logic [7:0] fifo[$];
  logic [7:0] sh = 8'h00, outb = 8'h00;
  logic [5:0] addr = 6'h00, last_cmd = 6'h00;
  logic       oe = 1'b0, last = 1'b0;
  int         st = 0, bits = 0;
  initial foreach (regs[i]) regs[i] = 8'h00;
  initial irq_o = 1'b0;
  function automatic logic [7:0] rd_reg(input logic [5:0] a);
    if (a == RO_ADDR) return RO_VAL;
    return a[5] ? 8'h00 : regs[a[4:0]];
  endfunction
  // only whole bytes act, so a cut byte is simply dropped
  always @(posedge ss_n_i) begin
    st = 0;
    bits = 0;
    oe = 1'b0;
  end
  always @(negedge ss_n_i) irq_o = 1'b0;
  always @(posedge sclk_i) if (!ss_n_i && (st == 3 || st == 4)) begin
    oe = 1'b1;
    last = outb[7-bits];
  end
  // released line: pull-down if enabled, else a changing level the host must not trust
  assign miso_o = oe ? last : ((regs[PD_ADDR[4:0]][1:0] != 2'h0) ? 1'b0 : ~last);
  always @(negedge sclk_i) if (!ss_n_i) begin
    sh = {sh[6:0], mosi_i};
    bits = bits + 1;
    if (bits == 8) begin
      bits = 0;
      case (st)
        0: begin
          addr = sh[5:0];
          case (sh[7:6])
            2'h0: st = 1;
            2'h1: begin st = 3; outb = rd_reg(addr); end
            2'h2: if (en_i && sh[5:0] == 6'h00) st = 2;
              else if (en_i && sh[5:0] == 6'h3F) begin st = 4; outb = fifo.size() ? fifo[0] : 8'h00; end
              else st = 5;
            default: begin
              last_cmd = sh[5:0];
              if (sh[5:0] == LONG_CMD && !irq_mute_i) fork #(LONG_NS) irq_o = 1'b1; join_none
            end
          endcase
        end
        1: begin if (!addr[5] && addr != RO_ADDR) regs[addr[4:0]] = sh; addr = addr + 6'h01; end
        2: if (fifo.size() < 96) fifo.push_back(sh);
        3: begin addr = addr + 6'h01; outb = rd_reg(addr); end
        4: begin void'(fifo.pop_front()); outb = fifo.size() ? fifo[0] : 8'h00; end
        default: ;
      endcase
    end
  end
endmodule // rsh_dev_model

// ==== sim/rsh_host_tb_top.sv ====
// self-checking bench for the serial host port controller
`timescale 1ns/1ps
module rsh_host_tb_top;
  import rsh_pkg::*;
  logic       clk_i = 1'b0, rst_i = 1'b1, req_valid = 1'b0, wr_valid = 1'b0, fifo_ok = 1'b1, mute = 1'b0;
  logic [7:0] wr_data = 8'h00, rd_data;
  logic       req_ready, wr_ready, rd_valid, busy, timeout, irq, miso;
  rsh_req_t   req = '0;
  rsh_pins_t  pins;
  logic [7:0] rdq[$];
  int         fail_count = 0, samples_checked = 0, cyc = 0;
  initial forever #20 clk_i = ~clk_i;
  rsh_host #(.IRQ_WAIT(50)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .req_i(req), .req_valid_i(req_valid),
    .req_ready_o(req_ready), .wr_valid_i(wr_valid), .wr_data_i(wr_data), .wr_ready_o(wr_ready), .rd_valid_o(rd_valid),
    .rd_data_o(rd_data), .busy_o(busy), .timeout_o(timeout), .miso_i(miso), .irq_i(irq), .fifo_ok_i(fifo_ok),
    .pins_o(pins));
  rsh_dev_model u_dev (.sclk_i(pins.sclk), .ss_n_i(pins.ss_n), .mosi_i(pins.mosi), .en_i(fifo_ok),
    .irq_mute_i(mute), .miso_o(miso), .irq_o(irq));
  always @(posedge clk_i) if (rd_valid === 1'b1) rdq.push_back(rd_data);
  task automatic give_verdict();
    if (fail_count == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      $display("mismatch at %0t: run timed out", $time);
      give_verdict();
    end
  end
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin fail_count++; $display("mismatch at %0t: byte %h expected %h", $time, got, exp); end
  endtask
  task automatic chk1(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin fail_count++; $display("mismatch at %0t: flag %b expected %b", $time, got, exp); end
  endtask
  task automatic put(input logic [7:0] b);
    @(posedge clk_i);
    wr_data <= b;
    wr_valid <= 1'b1;
    @(posedge clk_i);
    while (wr_ready !== 1'b1) @(posedge clk_i);
    wr_valid <= 1'b0;
  endtask
  task automatic run(input rsh_op_t op, input logic [5:0] a, input logic [6:0] n, input logic [5:0] c,
                     input logic hc, input logic lc);
    rdq.delete();
    @(posedge clk_i);
    req <= '{op, a, n, c, hc, lc};
    req_valid <= 1'b1;
    @(posedge clk_i);
    while (req_ready !== 1'b1) @(posedge clk_i);
    req_valid <= 1'b0;
    @(posedge clk_i);
    while (busy !== 1'b0) @(posedge clk_i);
    repeat (4) @(posedge clk_i);
  endtask
  // run crosses a read-only and an unimplemented address
  task automatic t_regs();
    for (int i = 0; i < 4; i++) put(8'h30 + 8'(i));
    run(RSH_OP_WRITE, 6'h1D, 7'h04, 6'h00, 1'b0, 1'b0);
    run(RSH_OP_READ, 6'h1D, 7'h04, 6'h00, 1'b0, 1'b0);
    chk8(8'(rdq.size()), 8'h04);
    chk8(rdq[0], 8'h30);
    chk8(rdq[1], 8'h31);
    chk8(rdq[2], 8'hA5);
    chk8(rdq[3], 8'h00);
  endtask
  task automatic t_chain();
    run(RSH_OP_READ, 6'h1D, 7'h01, 6'h05, 1'b1, 1'b0);
    chk8(rdq[0], 8'h30);
    chk8({2'h0, u_dev.last_cmd}, 8'h05);
  endtask
  task automatic t_fifo();
    for (int i = 0; i < 96; i++) put(8'(i * 3 + 1));
    run(RSH_OP_FIFO_LOAD, 6'h00, 7'h60, 6'h00, 1'b0, 1'b0);
    run(RSH_OP_FIFO_READ, 6'h00, 7'h60, 6'h00, 1'b0, 1'b0);
    chk8(8'(rdq.size()), 8'h60);
    for (int i = 0; i < 96; i++) chk8(rdq[i], 8'(i * 3 + 1));
  endtask
  task automatic t_refused();
    @(posedge clk_i);
    fifo_ok <= 1'b0;
    run(RSH_OP_FIFO_READ, 6'h00, 7'h02, 6'h00, 1'b0, 1'b0);
    chk8(8'(rdq.size()), 8'h00);
    fifo_ok <= 1'b1;
  endtask
  // a silent device must end in the timeout flag, not a hang
  task automatic t_long();
    run(RSH_OP_READ, 6'h00, 7'h01, 6'h3E, 1'b1, 1'b1);
    repeat (60) @(posedge clk_i);
    chk1(timeout, 1'b0);
    chk8(8'(rdq.size()), 8'h00);
    mute <= 1'b1;
    run(RSH_OP_READ, 6'h00, 7'h01, 6'h3E, 1'b1, 1'b1);
    repeat (60) @(posedge clk_i);
    chk1(timeout, 1'b1);
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_chain();
    t_fifo();
    t_refused();
    t_long();
    give_verdict();
  end
endmodule // rsh_host_tb_top
